// ---- ibds_pkg.sv ----
// Constants and types shared by the ISA-side signalling block
package ibds_pkg;
	localparam int unsigned ADDR_W          = 8;
	localparam logic [7:0]  OFF_CTRL        = 8'h00;
	localparam logic [7:0]  OFF_DMA_CMD     = 8'h04;
	localparam logic [7:0]  OFF_STATUS      = 8'h08;
	localparam int unsigned CTRL_ISA_RST    = 0;
	localparam int unsigned CTRL_EOP_IN     = 1;
	localparam int unsigned CMD_DREQ_HI     = 6;
	localparam int unsigned CMD_DACK_HI     = 7;
	localparam logic [1:0]  CTRL_RST_VAL    = 2'h0;
	localparam logic [7:0]  CMD_RST_VAL     = 8'h00;
	localparam int unsigned STAT_TC         = 8;
	localparam int unsigned STAT_REF_EXT    = 9;
	localparam int unsigned STAT_RSTDRV     = 10;
	localparam logic [23:0] LOW_MEM_LIMIT   = 24'h100000;
	localparam logic [3:0]  ZW_MEM16_CLKS   = 4'h2;
	localparam logic [3:0]  ZW_8BIT_CLKS    = 4'h3;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	localparam logic [1:0]  DEC_CTRL        = 2'h0;
	localparam logic [1:0]  DEC_CMD         = 2'h1;
	localparam logic [1:0]  DEC_STAT        = 2'h2;
	localparam logic [1:0]  DEC_NONE        = 2'h3;

	typedef enum logic [0:0] {
		CYC_IDLE = 1'b0,
		CYC_RUN  = 1'b1
	} ibds_cyc_e;

	typedef struct packed {
		logic is_mem;
		logic is16;
	} ibds_kind_s;
endpackage

// ---- ibds_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module ibds_sync #(
	parameter int unsigned W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         sys_clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] level_reg;
	logic [W-1:0] level_next;

	// A bit changes only once stages two and three agree
	always_comb begin
		for (int i = 0; i < W; i++) begin
			level_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : level_reg[i];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s1_reg    <= RST_VAL;
			s2_reg    <= RST_VAL;
			s3_reg    <= RST_VAL;
			level_reg <= RST_VAL;
		end else begin
			s1_reg    <= pin;
			s2_reg    <= s1_reg;
			s3_reg    <= s2_reg;
			level_reg <= level_next;
		end
	end

	assign level = level_reg;
endmodule

// ---- ibds_top.sv ----
// ISA-side strobes, cycle shortening, reset drive, DMA handshake and refresh
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module ibds_top #(
	parameter int unsigned  NCH        = 8,
	parameter logic [3:0]   MEM16_CLKS = 4'h3,
	parameter logic [3:0]   IO16_CLKS  = 4'h3,
	parameter logic [3:0]   BIT8_CLKS  = 4'h6
) (
	input  wire logic                       sys_clk,
	input  wire logic                       srst,
	input  wire logic [ibds_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [ibds_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       pci_rst_n,
	input  wire logic                       sysclk_pin,
	input  wire logic                       memw_n,
	input  wire logic                       memr_n,
	input  wire logic [23:0]                mem_addr,
	input  wire logic                       low_mem_cycle,
	output logic                            smemw_n,
	output logic                            smemr_n,
	input  wire logic                       cyc_start,
	input  wire ibds_pkg::ibds_kind_s       cyc_kind,
	input  wire logic                       zerows_n,
	input  wire logic                       iochrdy,
	output logic                            cyc_done,
	output logic                            rstdrv,
	input  wire logic [15:0]                sd_i,
	output logic [15:0]                     sd_o,
	output logic                            sd_oe,
	input  wire logic [15:0]                sd_wdata,
	input  wire logic                       sd_drive,
	output logic [15:0]                     sd_rdata,
	input  wire logic [NCH-1:0]             dreq,
	output logic [NCH-1:0]                  dreq_act,
	input  wire logic [NCH-1:0]             dma_grant,
	output logic [NCH-1:0]                  dack,
	input  wire logic                       dma_active,
	input  wire logic                       new_addr,
	input  wire logic                       count_expired,
	input  wire logic                       autoinit,
	input  wire logic                       aen,
	input  wire logic                       eop_i,
	output logic                            eop_o,
	output logic                            eop_oe,
	output logic                            dma_terminate,
	input  wire logic                       refresh_own,
	input  wire logic                       refresh_n_i,
	output logic                            refresh_n_o,
	output logic                            refresh_oe,
	output logic                            refresh_ext,
	input  wire logic                       sbhe_req_n,
	output logic                            sbhe_n,
	output logic                            memr_ref_n,
	output logic                            memr_ref_oe
);
	localparam int unsigned SW = 24 + NCH;
	// Idle pin levels: refresh high, process line low, ready, no zero-wait,
	// commands high, bus clock low, PCI reset released
	localparam logic [SW-1:0] SYNC_RST = {16'h0000, {NCH{1'b0}}, 8'hbd};

	// Synchronised pins
	logic [SW-1:0] pins_s;
	logic          pci_rst_n_s, sysclk_s, memw_n_s, memr_n_s;
	logic          zerows_n_s, iochrdy_s, eop_s, refresh_n_s;
	logic [NCH-1:0] dreq_s;
	logic [15:0]   sd_s;

	ibds_sync #(.W(SW), .RST_VAL(SYNC_RST)) u_sync (
		.sys_clk (sys_clk),
		.srst    (srst),
		.pin     ({sd_i, dreq, refresh_n_i, eop_i, iochrdy, zerows_n,
			memr_n, memw_n, sysclk_pin, pci_rst_n}),
		.level   (pins_s)
	);
	assign {sd_s, dreq_s, refresh_n_s, eop_s, iochrdy_s, zerows_n_s,
		memr_n_s, memw_n_s, sysclk_s, pci_rst_n_s} = pins_s;

	logic isa_rst;
	assign isa_rst = ~pci_rst_n_s;

	function automatic logic [1:0] dec(input logic [ibds_pkg::ADDR_W-1:0] a);
		if (a == ibds_pkg::OFF_CTRL) begin
			dec = ibds_pkg::DEC_CTRL;
		end else if (a == ibds_pkg::OFF_DMA_CMD) begin
			dec = ibds_pkg::DEC_CMD;
		end else if (a == ibds_pkg::OFF_STATUS) begin
			dec = ibds_pkg::DEC_STAT;
		end else begin
			dec = ibds_pkg::DEC_NONE;
		end
	endfunction

	// Register bus slave
	logic        awready_reg, awready_next, wready_reg, wready_next;
	logic        aw_have_reg, aw_have_next, w_have_reg, w_have_next;
	logic [ibds_pkg::ADDR_W-1:0] awaddr_reg, awaddr_next;
	logic [7:0]  wbyte_reg, wbyte_next;
	logic        wlane_reg, wlane_next;
	logic        bvalid_reg, bvalid_next, arready_reg, arready_next;
	logic        rvalid_reg, rvalid_next;
	logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next, status;
	logic [1:0]  ctrl_reg, ctrl_next;
	logic [7:0]  cmd_reg, cmd_next;
	logic        tc_reg, rstdrv_reg, refresh_ext_reg;
	logic [NCH-1:0] dreq_act_reg;

	always_comb begin
		status = 32'h0000_0000;
		status[NCH-1:0] = dreq_act_reg;
		status[ibds_pkg::STAT_TC] = tc_reg;
		status[ibds_pkg::STAT_REF_EXT] = refresh_ext_reg;
		status[ibds_pkg::STAT_RSTDRV] = rstdrv_reg;
	end

	always_comb begin
		awready_next = awready_reg;
		wready_next  = wready_reg;
		aw_have_next = aw_have_reg;
		w_have_next  = w_have_reg;
		awaddr_next  = awaddr_reg;
		wbyte_next   = wbyte_reg;
		wlane_next   = wlane_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		arready_next = arready_reg;
		rvalid_next  = rvalid_reg;
		rresp_next   = rresp_reg;
		rdata_next   = rdata_reg;
		ctrl_next    = ctrl_reg;
		cmd_next     = cmd_reg;
		if (s_axi_awvalid && awready_reg) begin
			awaddr_next  = s_axi_awaddr;
			aw_have_next = 1'b1;
			awready_next = 1'b0;
		end
		if (s_axi_wvalid && wready_reg) begin
			wbyte_next  = s_axi_wdata[7:0];
			wlane_next  = s_axi_wstrb[0];
			w_have_next = 1'b1;
			wready_next = 1'b0;
		end
		if (aw_have_reg && w_have_reg && !bvalid_reg) begin
			aw_have_next = 1'b0;
			w_have_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = ibds_pkg::RESP_OKAY;
			if (dec(awaddr_reg) == ibds_pkg::DEC_CTRL) begin
				ctrl_next = wlane_reg ? wbyte_reg[1:0] : ctrl_reg;
			end else if (dec(awaddr_reg) == ibds_pkg::DEC_CMD) begin
				cmd_next = wlane_reg ? wbyte_reg : cmd_reg;
			end else if (dec(awaddr_reg) == ibds_pkg::DEC_NONE) begin
				bresp_next = ibds_pkg::RESP_SLVERR;
			end
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next  = 1'b0;
			awready_next = 1'b1;
			wready_next  = 1'b1;
		end
		if (s_axi_arvalid && arready_reg) begin
			arready_next = 1'b0;
			rvalid_next  = 1'b1;
			rresp_next   = ibds_pkg::RESP_OKAY;
			rdata_next   = 32'h0000_0000;
			if (dec(s_axi_araddr) == ibds_pkg::DEC_CTRL) begin
				rdata_next[1:0] = ctrl_reg;
			end else if (dec(s_axi_araddr) == ibds_pkg::DEC_CMD) begin
				rdata_next[7:0] = cmd_reg;
			end else if (dec(s_axi_araddr) == ibds_pkg::DEC_STAT) begin
				rdata_next = status;
			end else begin
				rresp_next = ibds_pkg::RESP_SLVERR;
			end
		end
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next  = 1'b0;
			arready_next = 1'b1;
		end
		// PCI reset returns the command register to active-low handshakes
		if (isa_rst) begin
			cmd_next = ibds_pkg::CMD_RST_VAL;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			awaddr_reg  <= '0;
			wbyte_reg   <= 8'h00;
			wlane_reg   <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= ibds_pkg::RESP_OKAY;
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= ibds_pkg::RESP_OKAY;
			rdata_reg   <= 32'h0000_0000;
			ctrl_reg    <= ibds_pkg::CTRL_RST_VAL;
			cmd_reg     <= ibds_pkg::CMD_RST_VAL;
		end else begin
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			aw_have_reg <= aw_have_next;
			w_have_reg  <= w_have_next;
			awaddr_reg  <= awaddr_next;
			wbyte_reg   <= wbyte_next;
			wlane_reg   <= wlane_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg  <= rvalid_next;
			rresp_reg   <= rresp_next;
			rdata_reg   <= rdata_next;
			ctrl_reg    <= ctrl_next;
			cmd_reg     <= cmd_next;
		end
	end

	// Cycle timing in bus clocks, zero-wait and ready handling
	ibds_pkg::ibds_cyc_e  cyc_reg, cyc_next;
	ibds_pkg::ibds_kind_s kind_reg, kind_next;
	logic [3:0] cnt_reg, cnt_next, cnt_inc, norm_len, zw_len;
	logic       sysclk_q_reg, sys_rise, zw_ok, done_reg, done_next;

	assign sys_rise = sysclk_s & ~sysclk_q_reg;

	always_comb begin
		cyc_next  = cyc_reg;
		kind_next = kind_reg;
		cnt_next  = cnt_reg;
		done_next = 1'b0;
		cnt_inc   = cnt_reg + 4'h1;
		zw_len    = kind_reg.is16 ? ibds_pkg::ZW_MEM16_CLKS : ibds_pkg::ZW_8BIT_CLKS;
		norm_len  = !kind_reg.is16 ? BIT8_CLKS : (kind_reg.is_mem ? MEM16_CLKS : IO16_CLKS);
		// A wait request outranks zero-wait; 16-bit I/O ignores zero-wait
		zw_ok     = !zerows_n_s && iochrdy_s && !(kind_reg.is16 && !kind_reg.is_mem);
		case (cyc_reg)
			ibds_pkg::CYC_IDLE: begin
				if (cyc_start) begin
					cyc_next  = ibds_pkg::CYC_RUN;
					kind_next = cyc_kind;
					cnt_next  = 4'h0;
				end
			end
			ibds_pkg::CYC_RUN: begin
				if (sys_rise) begin
					if (iochrdy_s && ((zw_ok && cnt_inc >= zw_len) || cnt_inc >= norm_len)) begin
						cyc_next  = ibds_pkg::CYC_IDLE;
						done_next = 1'b1;
					end else if (cnt_reg != 4'hf) begin
						cnt_next = cnt_inc;
					end
				end
			end
			default: cyc_next = ibds_pkg::CYC_IDLE;
		endcase
		if (isa_rst) begin
			cyc_next = ibds_pkg::CYC_IDLE;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cyc_reg      <= ibds_pkg::CYC_IDLE;
			kind_reg     <= '0;
			cnt_reg      <= 4'h0;
			sysclk_q_reg <= 1'b0;
			done_reg     <= 1'b0;
		end else begin
			cyc_reg      <= cyc_next;
			kind_reg     <= kind_next;
			cnt_reg      <= cnt_next;
			sysclk_q_reg <= sysclk_s;
			done_reg     <= done_next;
		end
	end

	// Pin-side outputs
	logic smemw_reg, smemw_next, smemr_reg, smemr_next, rstdrv_next, low_mem;
	logic [15:0] sd_o_reg, sd_o_next, sd_rdata_reg;
	logic sd_oe_reg, sd_oe_next, ref_oe_next, ref_ext_next, ref_any;
	logic [NCH-1:0] dreq_act_next, dack_reg, dack_next;
	logic tc_next, eop_oe_reg, eop_oe_next, term_reg, term_next, aen_q_reg, in_mode;
	logic ref_oe_reg, sbhe_reg, sbhe_next, memr_oe_reg;

	assign low_mem = low_mem_cycle && (mem_addr < ibds_pkg::LOW_MEM_LIMIT);
	assign in_mode = dma_active && ctrl_reg[ibds_pkg::CTRL_EOP_IN];
	assign ref_any = refresh_own || refresh_ext_reg;

	always_comb begin
		smemw_next    = isa_rst ? 1'b1 : !(low_mem && !memw_n_s);
		smemr_next    = isa_rst ? 1'b1 : !(low_mem && !memr_n_s);
		rstdrv_next   = isa_rst || ctrl_reg[ibds_pkg::CTRL_ISA_RST];
		sd_oe_next    = sd_drive && !isa_rst && !rstdrv_reg && !ref_any;
		sd_o_next     = sd_wdata;
		dreq_act_next = cmd_reg[ibds_pkg::CMD_DREQ_HI] ? dreq_s : ~dreq_s;
		dack_next     = cmd_reg[ibds_pkg::CMD_DACK_HI] ? dma_grant : ~dma_grant;
		if (isa_rst) begin
			dack_next = {NCH{1'b1}};
		end
		// Count-done flag: set wins over the AEN or autoinit clear
		tc_next = tc_reg;
		if ((aen_q_reg && !aen) || autoinit) begin
			tc_next = 1'b0;
		end
		if (new_addr && count_expired && !in_mode) begin
			tc_next = 1'b1;
		end
		if (!dma_active || isa_rst) begin
			tc_next = 1'b0;
		end
		eop_oe_next  = !(in_mode && !isa_rst);
		term_next    = in_mode && eop_s && !isa_rst;
		ref_oe_next  = refresh_own && !isa_rst;
		ref_ext_next = !ref_oe_reg && !refresh_n_s && !isa_rst;
		sbhe_next    = sbhe_req_n || ref_any;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			smemw_reg       <= 1'b1;
			smemr_reg       <= 1'b1;
			rstdrv_reg      <= 1'b1;
			sd_oe_reg       <= 1'b0;
			sd_o_reg        <= 16'h0000;
			sd_rdata_reg    <= 16'h0000;
			dreq_act_reg    <= '0;
			dack_reg        <= {NCH{1'b1}};
			tc_reg          <= 1'b0;
			eop_oe_reg      <= 1'b1;
			term_reg        <= 1'b0;
			aen_q_reg       <= 1'b0;
			ref_oe_reg      <= 1'b0;
			refresh_ext_reg <= 1'b0;
			sbhe_reg        <= 1'b1;
			memr_oe_reg     <= 1'b0;
		end else begin
			smemw_reg       <= smemw_next;
			smemr_reg       <= smemr_next;
			rstdrv_reg      <= rstdrv_next;
			sd_oe_reg       <= sd_oe_next;
			sd_o_reg        <= sd_o_next;
			sd_rdata_reg    <= sd_s;
			dreq_act_reg    <= dreq_act_next;
			dack_reg        <= dack_next;
			tc_reg          <= tc_next;
			eop_oe_reg      <= eop_oe_next;
			term_reg        <= term_next;
			aen_q_reg       <= aen;
			ref_oe_reg      <= ref_oe_next;
			refresh_ext_reg <= ref_ext_next;
			sbhe_reg        <= sbhe_next;
			memr_oe_reg     <= ref_oe_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;
	assign smemw_n       = smemw_reg;
	assign smemr_n       = smemr_reg;
	assign cyc_done      = done_reg;
	assign rstdrv        = rstdrv_reg;
	assign sd_o          = sd_o_reg;
	assign sd_oe         = sd_oe_reg;
	assign sd_rdata      = sd_rdata_reg;
	assign dreq_act      = dreq_act_reg;
	assign dack          = dack_reg;
	assign eop_o         = tc_reg;
	assign eop_oe        = eop_oe_reg;
	assign dma_terminate = term_reg;
	assign refresh_n_o   = 1'b0;
	assign refresh_oe    = ref_oe_reg;
	assign refresh_ext   = refresh_ext_reg;
	assign sbhe_n        = sbhe_reg;
	assign memr_ref_n    = 1'b0;
	assign memr_ref_oe   = memr_oe_reg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	a_smemw_follow: assert property ((low_mem && !memw_n_s && !isa_rst) |=> !smemw_n)
		else $error("write strobe did not follow");
	a_smemr_follow: assert property ((!low_mem && !isa_rst) |=> smemr_n)
		else $error("read strobe active outside low memory");
	a_smemw_reset: assert property (isa_rst |=> smemw_n)
		else $error("write strobe low during reset");
	a_zw_16io: assert property ((cyc_reg == ibds_pkg::CYC_RUN && kind_reg.is16 && !kind_reg.is_mem
		&& sys_rise && cnt_reg == 4'h0 && IO16_CLKS > 4'h1) |=> !done_reg)
		else $error("zero wait shortened 16-bit io");
	a_ready_wins: assert property ((cyc_reg == ibds_pkg::CYC_RUN && !iochrdy_s) |=> !done_reg)
		else $error("cycle ended during wait request");
	a_rstdrv_src: assert property (!$past(srst)
		|-> rstdrv_reg == $past(isa_rst || ctrl_reg[ibds_pkg::CTRL_ISA_RST]))
		else $error("reset drive wrong");
	a_sd_float: assert property ((isa_rst || rstdrv_reg) |=> !sd_oe_reg)
		else $error("data driven during reset");
	a_dreq_pol: assert property (!$past(srst) |-> dreq_act_reg ==
		($past(cmd_reg[ibds_pkg::CMD_DREQ_HI]) ? $past(dreq_s) : ~$past(dreq_s)))
		else $error("request polarity wrong");
	a_dack_rst: assert property (isa_rst |=> dack_reg == {NCH{1'b1}})
		else $error("acknowledge not inactive after reset");
	a_eop_term: assert property ((in_mode && eop_s && !isa_rst) |=> term_reg && !eop_oe_reg)
		else $error("termination not seen");
	a_tc_set: assert property ((dma_active && !isa_rst && new_addr && count_expired && !in_mode)
		|=> tc_reg ##1 (tc_reg || !aen || autoinit || !dma_active))
		else $error("count done flag not set");
	a_eop_idle: assert property (!dma_active |=> eop_oe_reg && !tc_reg)
		else $error("process line not low output when idle");
	a_ref_drive: assert property ((refresh_own && !isa_rst) |=> refresh_oe && memr_ref_oe && sbhe_n)
		else $error("own refresh not driven");
	a_ref_float: assert property (isa_rst |=> !refresh_oe)
		else $error("refresh driven after reset");

	c_zw_short: cover property (zw_ok && done_next);
	c_tc_out: cover property (tc_reg ##[1:20] !tc_reg);
	c_ext_ref: cover property (refresh_ext_reg);
	c_axi_wr: cover property (bvalid_reg && s_axi_bready);
endmodule

// ---- ibds_isa_model.sv ----
// Behavioural ISA far side: bus clock, DMA requesters, terminator and refresh master
`timescale 1ns/100ps
module ibds_isa_model (
	output logic            sysclk_pin,
	output logic [7:0]      dreq,
	output logic            eop_i,
	output logic            refresh_n_i,
	input  wire logic [7:0] dack,
	input  wire logic [7:0] want_req,
	input  wire logic       req_hi,
	input  wire logic       dack_hi,
	input  wire logic       stop,
	input  wire logic       ext_ref
);
	logic [7:0] pend = 8'h00;

	initial begin
		sysclk_pin = 1'b0;
		forever #62.5 sysclk_pin = ~sysclk_pin;
	end

	// A request stays up until its acknowledge shows at the active level
	always @(posedge sysclk_pin) begin
		pend <= (pend | want_req) & ~(dack_hi ? dack : ~dack);
	end

	assign dreq = req_hi ? pend : ~pend;
	assign eop_i = stop;
	// Pulled-up line, low only while a bus master runs a refresh
	assign refresh_n_i = ~ext_ref;
endmodule

// ---- ibds_tb_top.sv ----
// Self-checking bench for the ISA-side signalling block
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module ibds_tb_top;
	logic sys_clk, srst, pci_rst_n, memw_n, memr_n, low_mem_cycle, cyc_start, zerows_n, iochrdy;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sysclk_pin, smemw_n, smemr_n;
	logic cyc_done, rstdrv, sd_oe, sd_drive, dma_active, new_addr, count_expired, autoinit, aen;
	logic eop_i, eop_o, eop_oe, dma_terminate, refresh_own, refresh_n_i, refresh_n_o, refresh_oe;
	logic refresh_ext, sbhe_req_n, sbhe_n, memr_ref_n, memr_ref_oe, req_hi, dack_hi, stop, ext_ref;
	logic        p;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, dreq, dreq_act, dma_grant, dack, want_req;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [3:0]  s_axi_wstrb;
	logic [23:0] mem_addr;
	logic [15:0] sd_i, sd_o, sd_wdata, sd_rdata;
	ibds_pkg::ibds_kind_s cyc_kind;
	int          n_fail, n_tests, n;

	ibds_top DUT (.*);
	ibds_isa_model PTN (.*);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid || s_axi_wvalid);
		while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
		rd_val = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Times one cycle in bus clock edges; slow holds the ready line low for four edges
	task automatic cyc(input logic [1:0] k, input logic zw, input logic slow, input int e);
		iochrdy <= ~slow;
		@(posedge sysclk_pin);
		repeat (8) @(posedge sys_clk);
		cyc_kind <= ibds_pkg::ibds_kind_s'(k);
		cyc_start <= 1'b1;
		n = 0;
		@(posedge sys_clk);
		cyc_start <= 1'b0;
		zerows_n <= ~zw;
		p = sysclk_pin;
		while (cyc_done !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			if (sysclk_pin && !p) n++;
			p = sysclk_pin;
			if (n == 4) iochrdy <= 1'b1;
		end
		zerows_n <= 1'b1;
		`CHK(n, e)
	endtask

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr,
			s_axi_araddr, s_axi_wdata, pci_rst_n, memw_n, mem_addr, cyc_start, cyc_kind, dma_grant,
			dma_active, new_addr, count_expired, autoinit, aen, refresh_own, sbhe_req_n, req_hi,
			dack_hi, stop, ext_ref, want_req, n_fail, n_tests} = '0;
		{srst, low_mem_cycle, zerows_n, iochrdy, sd_drive, memr_n} = '1;
		s_axi_wstrb = 4'hf;
		sd_i = 16'h5aa5;
		sd_wdata = 16'h1234;
		tick(12);
		`CHK(smemw_n, 1'b1)
		srst <= 1'b0;
		tick(10);
		`CHK(rstdrv, 1'b1)
		`CHK(dack, 8'hff)
		`CHK({eop_oe, eop_o}, 2'b10)
		`CHK(refresh_oe, 1'b0)
		`CHK(sd_oe, 1'b0)
		`CHK(smemw_n, 1'b1)
		pci_rst_n <= 1'b1;
		tick(10);
		`CHK(rstdrv, 1'b0)
		`CHK(smemw_n, 1'b0)
		`CHK(sd_oe, 1'b1)
		`CHK(sd_o, 16'h1234)
		`CHK(sd_rdata, 16'h5aa5)
		mem_addr <= 24'h100000;
		memr_n <= 1'b0;
		tick(8);
		`CHK({smemw_n, smemr_n}, 2'b11)
		mem_addr <= 24'h0fffff;
		tick(8);
		`CHK(smemr_n, 1'b0)
		{memw_n, memr_n} <= 2'b11;
		rd(8'h40);
		`CHK(resp, ibds_pkg::RESP_SLVERR)
		wr(ibds_pkg::OFF_CTRL, 32'h1);
		tick(2);
		`CHK(rstdrv, 1'b1)
		tick(100); // Software keeps the bus reset up for 1 us
		wr(ibds_pkg::OFF_CTRL, 32'h0);
		tick(2);
		`CHK(rstdrv, 1'b0)
		for (int i = 0; i < 4; i++) begin
			wr(ibds_pkg::OFF_DMA_CMD, 32'(i) << 6);
			req_hi <= i[0];
			dack_hi <= i[1];
			want_req <= 8'h01;
			rd(ibds_pkg::OFF_DMA_CMD);
			`CHK(rd_val, 32'(i) << 6)
			tick(30);
			`CHK(dreq_act, 8'h01)
			dma_grant <= 8'h01;
			tick(30);
			// Slave side would gate this acknowledge with its I/O command
			`CHK(dack, i[1] ? 8'h01 : 8'hfe)
			`CHK(dreq_act, 8'h00)
			want_req <= 8'h00;
			dma_grant <= 8'h00;
		end
		cyc(2'b11, 1'b1, 1'b0, 2);
		cyc(2'b10, 1'b1, 1'b0, 3);
		cyc(2'b00, 1'b1, 1'b0, 3);
		cyc(2'b01, 1'b1, 1'b0, 3);
		cyc(2'b11, 1'b0, 1'b0, 3);
		cyc(2'b11, 1'b1, 1'b1, 5);
		{dma_active, aen, new_addr, count_expired} <= 4'hf;
		tick(1);
		{new_addr, count_expired} <= 2'b00;
		tick(5);
		`CHK({eop_oe, eop_o}, 2'b11)
		aen <= 1'b0;
		tick(3);
		`CHK(eop_o, 1'b0)
		{aen, new_addr, count_expired} <= 3'b111;
		tick(1);
		{new_addr, count_expired} <= 2'b00;
		tick(3);
		autoinit <= 1'b1;
		tick(1);
		autoinit <= 1'b0;
		tick(2);
		`CHK(eop_o, 1'b0)
		{dma_active, aen} <= 2'b00;
		tick(3);
		`CHK({eop_oe, eop_o}, 2'b10)
		wr(ibds_pkg::OFF_CTRL, 32'h2);
		{dma_active, stop} <= 2'b11;
		tick(10);
		`CHK({eop_oe, dma_terminate}, 2'b01)
		{dma_active, stop} <= 2'b00;
		refresh_own <= 1'b1;
		tick(3);
		`CHK({refresh_oe, memr_ref_oe, sbhe_n, memr_ref_n}, 4'b1110)
		// Memory slaves stay off the data lines while refresh runs
		`CHK(sd_oe, 1'b0)
		`CHK(refresh_n_o, 1'b0)
		refresh_own <= 1'b0;
		ext_ref <= 1'b1;
		tick(10);
		`CHK({refresh_oe, refresh_ext, sbhe_n}, 3'b011)
		rd(ibds_pkg::OFF_STATUS);
		`CHK(rd_val, 32'h0000_0200)
		`CHK(resp, ibds_pkg::RESP_OKAY)
		summarize;
	end

	initial begin
		repeat (50000) @(posedge sys_clk);
		n_fail++;
		summarize;
	end
endmodule
